// File: wl_defs.svh
/*
  Constants for the write leveling pair: mode register layout, register
  offsets and timing counts. Assumes a 4 ns system clock on both ends.
*/
`ifndef WL_DEFS_SVH
`define WL_DEFS_SVH

// ****************************************
// Mode register one layout
// ****************************************
`define WL_BA_MR1 3'h1
`define WL_MR1_LVL_BIT 7
`define WL_MR1_QOFF_BIT 12
`define WL_MR1_RTT0_BIT 2
`define WL_MR1_RTT1_BIT 6
`define WL_MR1_RTT2_BIT 9
`define WL_RTT_DIV4 3'h1
`define WL_RTT_DIV2 3'h2
`define WL_RTT_DIV6 3'h3

// ****************************************
// Controller registers
// ****************************************
`define WL_REG_CTRL 8'h00
`define WL_REG_STATUS 8'h04
`define WL_REG_DELAY 8'h08
`define WL_CTRL_START_BIT 0
`define WL_CTRL_RTT_LSB 1
`define WL_CTRL_RANK_LSB 4
`define WL_RTT_RESET 3'h1
`define WL_RANK_RESET 2'h0

// ****************************************
// Timing
// ****************************************
`define WL_PCLK_NS 4
`define WL_MOD_NS 60
`define WL_MRD_NS 40
`define WL_DQSEN_NS 100
`define WL_DQSL_NS 40
`define WL_FIRST_NS 160
`define WL_WLO_NS 8
`define WL_WLOE_NS 4
`define WL_ODT_OFF_NS 40
`define WL_CYC_MIN(t) (((t) + `WL_PCLK_NS - 1) / `WL_PCLK_NS)
`define WL_CYC_MAX(t) ((((t) / `WL_PCLK_NS) < 1) ? 1 : ((t) / `WL_PCLK_NS))
`define WL_MOD_CYC `WL_CYC_MIN(`WL_MOD_NS)
`define WL_MRD_CYC `WL_CYC_MIN(`WL_MRD_NS)
`define WL_DQSEN_CYC `WL_CYC_MIN(`WL_DQSEN_NS)
`define WL_DQSL_CYC `WL_CYC_MIN(`WL_DQSL_NS)
`define WL_FIRST_CYC `WL_CYC_MIN(`WL_FIRST_NS)
`define WL_WLO_CYC `WL_CYC_MAX(`WL_WLO_NS)
`define WL_WLOE_CYC `WL_CYC_MIN(`WL_WLOE_NS)
`define WL_ODT_OFF_CYC `WL_CYC_MIN(`WL_ODT_OFF_NS)
`define WL_SYNC_LAT 6

`endif

// File: wl_pkg.sv
/*
  Types shared by the write leveling ends.
  Assumes wl_defs.svh supplies all numeric constants.
*/
package wl_pkg;
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_MRS_OTH = 12'h002,
    ST_MRS_EN = 12'h004,
    ST_ODT_ON = 12'h008,
    ST_DQS_LOW = 12'h010,
    ST_ALIGN = 12'h020,
    ST_PULSE = 12'h040,
    ST_FBW = 12'h080,
    ST_STOP = 12'h100,
    ST_ODT_OFF = 12'h200,
    ST_MRS_DIS = 12'h400,
    ST_WAIT = 12'h800
  } wl_state_t;
endpackage

// File: wl_link_if.sv
/*
  Link between controller and memory device during write leveling.
  Assumes undriven data and strobe wires settle low at the receiver.
*/
`timescale 1ns/1ps
interface wl_link_if #(parameter int LANES = 2, parameter int RANKS = 2) ();
  logic ck;
  logic [RANKS-1:0] cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  logic odt;
  logic [LANES-1:0] dqs_o;
  logic [LANES-1:0] dqs_n_o;
  logic [LANES-1:0] dqs_oe;
  logic [LANES*8-1:0] dq_o;
  logic dq_oe;
  logic [LANES-1:0] dqs_w;
  logic [LANES-1:0] dqs_n_w;
  logic [LANES*8-1:0] dq_w;

  // Wire levels resolved here, design files never see a floating value
  assign dqs_w = dqs_o & dqs_oe;
  assign dqs_n_w = dqs_n_o & dqs_oe;
  assign dq_w = dq_oe ? dq_o : '0;

  modport ctrl (
    output ck, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dqs_o, dqs_n_o, dqs_oe,
    input dq_w
  );
  modport dram (
    input ck, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dqs_w, dqs_n_w,
    output dq_o, dq_oe
  );
endinterface

// File: wl_sync.sv
/*
  Two-stage synchroniser with rising edge detect per bit.
  Assumes inputs are asynchronous to pclk.
*/
`timescale 1ns/1ps
module wl_sync #(parameter int W = 1) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign q = s2_ff;
  assign rise = s2_ff & ~s3_ff;
endmodule // wl_sync

// File: wl_dram_end.sv
/*
  Memory device end of write leveling: mode register one decode,
  strobe termination and clock sample feedback on the data pins.
  Assumes the controller end drives ck, commands and strobes.
*/
`timescale 1ns/1ps
`include "wl_defs.svh"
module wl_dram_end import wl_pkg::*; #(
  parameter int RANK_ID = 0,
  parameter int LANES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  wl_link_if.dram link,
  output logic leveling_on,
  output logic outputs_off,
  output logic [LANES-1:0] strobe_term_on,
  output logic data_term_on,
  output logic mrs_ready,
  output logic cmd_ready
);
  localparam int SW = 23 + LANES;

  initial
  begin
    if (LANES < 1 || LANES > 2 || RANK_ID < 0)
      $error("wl_dram_end: unsupported LANES or RANK_ID");
  end

  // ****************************************
  // Pin capture
  // ****************************************
  logic [SW-1:0] s_q;
  logic [SW-1:0] s_rise;
  logic s_ck;
  logic s_odt;
  logic ck_rise;
  logic mrs_hit;
  logic [13:0] s_addr;
  logic [LANES-1:0] dqs_rise;

  wl_sync #(.W(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.ck, link.odt, link.cs_n[RANK_ID], link.ras_n, link.cas_n, link.we_n,
        link.ba, link.addr, link.dqs_w & ~link.dqs_n_w}),
    .q(s_q),
    .rise(s_rise)
  );

  assign s_ck = s_q[SW-1];
  assign s_odt = s_q[SW-2];
  assign ck_rise = s_rise[SW-1];
  assign s_addr = s_q[LANES +: 14];
  assign dqs_rise = s_rise[LANES-1:0];
  // Only mode register one writes matter; every other command is ignored
  assign mrs_hit = ck_rise && (s_q[SW-3 -: 4] == 4'h0) && (s_q[LANES+14 +: 3] == `WL_BA_MR1);

  // ****************************************
  // Mode, timers and feedback
  // ****************************************
  logic lvl_ff, nxt_lvl;
  logic qoff_ff, nxt_qoff;
  logic und_ff, nxt_und;
  logic [7:0] mrd_ff, nxt_mrd;
  logic [7:0] mod_ff, nxt_mod;
  logic [LANES-1:0] smp_ff, nxt_smp;
  logic [LANES-1:0] fb_ff, nxt_fb;
  logic [7:0] wlo_ff [LANES];
  logic [7:0] nxt_wlo [LANES];
  logic [LANES-1:0] sterm_ff, nxt_sterm;
  logic dterm_ff, nxt_dterm;
  logic dq_oe_ff, nxt_dq_oe;
  logic [LANES*8-1:0] dq_ff, nxt_dq;

  always_comb
  begin
    nxt_lvl = lvl_ff;
    nxt_qoff = qoff_ff;
    nxt_und = und_ff;
    nxt_mrd = (mrd_ff != 8'h00) ? mrd_ff - 8'h01 : 8'h00;
    nxt_mod = (mod_ff != 8'h00) ? mod_ff - 8'h01 : 8'h00;
    if (und_ff && mod_ff == 8'h01)
      nxt_und = 1'b0; // see RQ14
    if (mrs_hit)
    begin
      nxt_lvl = s_addr[`WL_MR1_LVL_BIT]; // see RQ1
      nxt_qoff = s_addr[`WL_MR1_QOFF_BIT]; // see RQ3
      nxt_mrd = 8'(`WL_MRD_CYC); // see RQ17
      nxt_mod = 8'(`WL_MOD_CYC); // see RQ17
      if (lvl_ff && !s_addr[`WL_MR1_LVL_BIT])
        nxt_und = 1'b1; // see RQ14
    end
    for (int l = 0; l < LANES; l++)
    begin
      nxt_smp[l] = smp_ff[l];
      nxt_fb[l] = fb_ff[l];
      nxt_wlo[l] = (wlo_ff[l] != 8'h00) ? wlo_ff[l] - 8'h01 : 8'h00;
      if (wlo_ff[l] == 8'h01)
        nxt_fb[l] = smp_ff[l]; // see RQ11
      if (lvl_ff && dqs_rise[l])
      begin
        nxt_smp[l] = s_ck; // see RQ19
        nxt_wlo[l] = 8'(`WL_WLO_CYC); // see RQ11
      end
      if (!lvl_ff)
        nxt_fb[l] = 1'b0;
      nxt_dq[l*8 +: 8] = {8{nxt_fb[l]}}; // see RQ18
      nxt_sterm[l] = nxt_lvl && s_odt; // see RQ2
    end
    // Pins drive low from entry until the first result
    nxt_dq_oe = !nxt_qoff && (nxt_lvl || nxt_und); // see RQ5
    nxt_dterm = !nxt_lvl && s_odt; // see RQ2
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_ff <= 1'b0;
      qoff_ff <= 1'b0;
      und_ff <= 1'b0;
      mrd_ff <= 8'h00;
      mod_ff <= 8'h00;
      smp_ff <= '0;
      fb_ff <= '0;
      sterm_ff <= '0;
      dterm_ff <= 1'b0;
      dq_oe_ff <= 1'b0;
      dq_ff <= '0;
      for (int l = 0; l < LANES; l++)
        wlo_ff[l] <= 8'h00;
    end
    else
    begin
      lvl_ff <= nxt_lvl;
      qoff_ff <= nxt_qoff;
      und_ff <= nxt_und;
      mrd_ff <= nxt_mrd;
      mod_ff <= nxt_mod;
      smp_ff <= nxt_smp;
      fb_ff <= nxt_fb;
      sterm_ff <= nxt_sterm;
      dterm_ff <= nxt_dterm;
      dq_oe_ff <= nxt_dq_oe;
      dq_ff <= nxt_dq;
      for (int l = 0; l < LANES; l++)
        wlo_ff[l] <= nxt_wlo[l];
    end
  end

  assign link.dq_o = dq_ff;
  assign link.dq_oe = dq_oe_ff;
  assign leveling_on = lvl_ff;
  assign outputs_off = qoff_ff;
  assign strobe_term_on = sterm_ff;
  assign data_term_on = dterm_ff;
  assign mrs_ready = (mrd_ff == 8'h00);
  assign cmd_ready = (mod_ff == 8'h00);
endmodule // wl_dram_end

// File: wl_ctrl_end.sv
/*
  Controller end of write leveling: APB slave registers, clock divider,
  command sequencing, strobe delay sweep per byte lane and exit.
  Assumes one device rank on the link answers and others are idle.
*/
`timescale 1ns/1ps
`include "wl_defs.svh"
// What this block and the device end do
// RQ1: Leveling bit set enters, cleared leaves
// RQ2: Termination pin switches strobe termination only
// RQ3: Output off bit disables data outputs
// RQ4: Enabled outputs allow only three termination values
// RQ5: Data pins undefined right after entry
// RQ6: Only deselect, no-op or exit write
// RQ7: Level one rank, others outputs off
// RQ8: Termination only after mode-to-command delay
// RQ9: Strobes low after strobe enable delay
// RQ10: One strobe edge per trial after delays
// RQ11: Device returns clock sample after output delay
// RQ12: Wait out feedback skew before sampling
// RQ13: Sweep delay, freeze on zero-to-one change
// RQ14: Release strobes, data undefined until delay
// RQ15: Drive termination low and keep low
// RQ16: Exit write only after termination off
// RQ17: Mode cycle and command delays after exit
// RQ18: Each byte lane leveled separately
// RQ19: Feedback level equals sampled clock level
module wl_ctrl_end import wl_pkg::*; #(
  parameter int LANES = 2,
  parameter int RANKS = 2,
  parameter int DIV = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  wl_link_if.ctrl link
);
  localparam logic [7:0] HALF = 8'(DIV);
  localparam logic [7:0] LAST = 8'(2 * DIV - 1);

  initial
  begin
    if (LANES < 1 || LANES > 2 || RANKS < 1 || RANKS > 4 || DIV < 2 || DIV > 100)
      $error("wl_ctrl_end: unsupported LANES, RANKS or DIV");
  end

  function automatic logic [13:0] mr1_word(logic lvl, logic qoff, logic [2:0] rtt);
    logic [13:0] w;
    w = 14'h0000;
    w[`WL_MR1_LVL_BIT] = lvl;
    w[`WL_MR1_QOFF_BIT] = qoff;
    w[`WL_MR1_RTT0_BIT] = rtt[0];
    w[`WL_MR1_RTT1_BIT] = rtt[1];
    w[`WL_MR1_RTT2_BIT] = rtt[2];
    return w;
  endfunction

  // ****************************************
  // Link clock divider
  // ****************************************
  logic [7:0] div_ff, nxt_div;
  logic ck_ff, nxt_ck;
  logic slot;

  always_comb
  begin
    nxt_div = (div_ff == LAST) ? 8'h00 : div_ff + 8'h01;
    nxt_ck = (nxt_div < HALF);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_ff <= 8'h00;
      ck_ff <= 1'b1;
    end
    else
    begin
      div_ff <= nxt_div;
      ck_ff <= nxt_ck;
    end
  end

  // Commands change with the falling ck edge, so they are centred on the rise
  assign slot = (div_ff == HALF - 8'h01);

  // ****************************************
  // Feedback capture
  // ****************************************
  logic [LANES*8-1:0] dq_s;
  logic [LANES-1:0] lane_fb;

  wl_sync #(.W(LANES*8)) u_dq_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.dq_w),
    .q(dq_s),
    .rise()
  );

  always_comb
  begin
    for (int l = 0; l < LANES; l++)
      lane_fb[l] = &dq_s[l*8 +: 8]; // see RQ12
  end

  // ****************************************
  // APB registers
  // ****************************************
  wl_state_t st_ff, nxt_st;
  logic [2:0] rtt_ff, nxt_rtt;
  logic [1:0] rank_ff, nxt_rank;
  logic [31:0] rd_ff, nxt_rd;
  logic done_ff, fail_ff, refused_ff;
  logic [7:0] dly_ff [LANES];
  logic wr_ctrl, mapped, start_ok, start_bad;

  assign mapped = (paddr == `WL_REG_CTRL) || (paddr == `WL_REG_STATUS) ||
                  (paddr == `WL_REG_DELAY);
  assign wr_ctrl = psel && penable && pwrite && (paddr == `WL_REG_CTRL) &&
                   (st_ff == ST_IDLE);
  // Termination must be one of three values because own outputs stay on
  assign start_bad = !(pwdata[3:1] == `WL_RTT_DIV2 || pwdata[3:1] == `WL_RTT_DIV4 ||
                       pwdata[3:1] == `WL_RTT_DIV6) || (32'(pwdata[5:4]) >= RANKS); // see RQ4
  assign start_ok = wr_ctrl && pwdata[`WL_CTRL_START_BIT] && !start_bad;

  always_comb
  begin
    nxt_rtt = rtt_ff;
    nxt_rank = rank_ff;
    nxt_rd = rd_ff;
    if (wr_ctrl)
    begin
      nxt_rtt = pwdata[`WL_CTRL_RTT_LSB +: 3];
      nxt_rank = pwdata[`WL_CTRL_RANK_LSB +: 2];
    end
    if (psel && !penable)
    begin
      case (paddr)
        `WL_REG_CTRL: nxt_rd = {26'h0, rank_ff, rtt_ff, 1'b0};
        `WL_REG_STATUS: nxt_rd = {28'h0, refused_ff, fail_ff, done_ff, st_ff != ST_IDLE};
        `WL_REG_DELAY: nxt_rd = {16'h0, (LANES > 1) ? dly_ff[LANES-1] : 8'h00, dly_ff[0]};
        default: nxt_rd = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rtt_ff <= `WL_RTT_RESET;
      rank_ff <= `WL_RANK_RESET;
      rd_ff <= 32'h0;
    end
    else
    begin
      rtt_ff <= nxt_rtt;
      rank_ff <= nxt_rank;
      rd_ff <= nxt_rd;
    end
  end

  assign prdata = rd_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ****************************************
  // Leveling sequencer
  // ****************************************
  wl_state_t ret_ff, nxt_ret;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [1:0] lane_ff, nxt_lane;
  logic prev_ff, nxt_prev;
  logic nxt_done, nxt_fail, nxt_refused;
  logic [7:0] nxt_dly [LANES];
  logic [RANKS-1:0] cs_ff, nxt_cs;
  logic [2:0] rcw_ff, nxt_rcw;
  logic [13:0] addr_ff, nxt_addr;
  logic [2:0] ba_ff, nxt_ba;
  logic odt_ff, nxt_odt;
  logic [LANES-1:0] dqs_ff, nxt_dqs;
  logic dqs_oe_ff, nxt_dqs_oe;
  logic [RANKS-1:0] tgt;
  logic fb;

  assign tgt = RANKS'(1) << rank_ff;
  assign fb = lane_fb[lane_ff[0]];

  always_comb
  begin
    nxt_st = st_ff;
    nxt_ret = ret_ff;
    nxt_cnt = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
    nxt_lane = lane_ff;
    nxt_prev = prev_ff;
    nxt_done = done_ff;
    nxt_fail = fail_ff;
    nxt_refused = refused_ff;
    for (int l = 0; l < LANES; l++)
      nxt_dly[l] = dly_ff[l];
    nxt_cs = cs_ff;
    nxt_rcw = rcw_ff;
    nxt_addr = addr_ff;
    nxt_ba = ba_ff;
    nxt_odt = odt_ff;
    nxt_dqs = dqs_ff;
    nxt_dqs_oe = dqs_oe_ff;
    if (slot)
    begin
      nxt_cs = '1; // see RQ6
      nxt_rcw = 3'h7;
    end
    case (st_ff)
      ST_IDLE:
      begin
        if (wr_ctrl && pwdata[`WL_CTRL_START_BIT])
        begin
          nxt_refused = start_bad;
          nxt_done = 1'b0;
          nxt_fail = 1'b0;
        end
        if (start_ok)
        begin
          nxt_lane = 2'h0;
          nxt_st = (RANKS > 1) ? ST_MRS_OTH : ST_MRS_EN;
        end
      end
      ST_MRS_OTH: if (slot)
      begin
        nxt_cs = tgt;
        nxt_rcw = 3'h0;
        nxt_ba = `WL_BA_MR1;
        nxt_addr = mr1_word(1'b0, 1'b1, rtt_ff); // see RQ7
        nxt_cnt = 8'(`WL_MRD_CYC + DIV);
        nxt_ret = ST_MRS_EN;
        nxt_st = ST_WAIT;
      end
      ST_MRS_EN: if (slot)
      begin
        nxt_cs = ~tgt;
        nxt_rcw = 3'h0;
        nxt_ba = `WL_BA_MR1;
        nxt_addr = mr1_word(1'b1, 1'b0, rtt_ff);
        nxt_cnt = 8'(`WL_MOD_CYC + DIV); // see RQ8
        nxt_ret = ST_ODT_ON;
        nxt_st = ST_WAIT;
      end
      ST_ODT_ON: if (slot)
      begin
        nxt_odt = 1'b1;
        nxt_cnt = 8'(`WL_DQSEN_CYC); // see RQ9
        nxt_ret = ST_DQS_LOW;
        nxt_st = ST_WAIT;
      end
      ST_DQS_LOW:
      begin
        nxt_dqs_oe = 1'b1; // see RQ9
        nxt_dqs = '0;
        for (int l = 0; l < LANES; l++)
          nxt_dly[l] = 8'h00;
        nxt_prev = 1'b1;
        nxt_cnt = 8'(`WL_DQSL_CYC + `WL_FIRST_CYC); // see RQ10
        nxt_ret = ST_ALIGN;
        nxt_st = ST_WAIT;
      end
      ST_ALIGN: if (div_ff == dly_ff[lane_ff[0]])
      begin
        nxt_dqs[lane_ff[0]] = 1'b1; // see RQ10
        // Count ends at zero, so high for exactly DIV cycles
        nxt_cnt = HALF - 8'h01;
        nxt_st = ST_PULSE;
      end
      ST_PULSE: if (cnt_ff == 8'h00)
      begin
        nxt_dqs = '0;
        nxt_cnt = 8'(`WL_WLO_CYC + `WL_WLOE_CYC + `WL_SYNC_LAT); // see RQ12
        nxt_st = ST_FBW;
      end
      ST_FBW: if (cnt_ff == 8'h00)
      begin
        nxt_prev = fb;
        nxt_cnt = 8'(`WL_DQSL_CYC);
        nxt_ret = ST_ALIGN;
        nxt_st = ST_WAIT;
        if (!prev_ff && fb)
        begin
          // Delay stays frozen at the value that gave the first one
          nxt_prev = 1'b1; // see RQ13
          if (32'(lane_ff) < LANES - 1)
            nxt_lane = lane_ff + 2'h1; // see RQ18
          else
            nxt_st = ST_STOP;
        end
        else if (dly_ff[lane_ff[0]] == LAST)
        begin
          nxt_fail = 1'b1;
          nxt_st = ST_STOP;
        end
        else
          nxt_dly[lane_ff[0]] = dly_ff[lane_ff[0]] + 8'h01; // see RQ13
      end
      ST_STOP:
      begin
        nxt_dqs_oe = 1'b0; // see RQ14
        nxt_st = ST_ODT_OFF;
      end
      ST_ODT_OFF: if (slot)
      begin
        nxt_odt = 1'b0; // see RQ15
        nxt_cnt = 8'(`WL_ODT_OFF_CYC); // see RQ16
        nxt_ret = ST_MRS_DIS;
        nxt_st = ST_WAIT;
      end
      ST_MRS_DIS: if (slot)
      begin
        nxt_cs = ~tgt;
        nxt_rcw = 3'h0;
        nxt_ba = `WL_BA_MR1;
        nxt_addr = mr1_word(1'b0, 1'b0, rtt_ff); // see RQ1
        nxt_done = !fail_ff;
        nxt_cnt = 8'(`WL_MOD_CYC + DIV); // see RQ17
        nxt_ret = ST_IDLE;
        nxt_st = ST_WAIT;
      end
      ST_WAIT: if (cnt_ff == 8'h00)
        nxt_st = ret_ff;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= ST_IDLE;
      ret_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      lane_ff <= 2'h0;
      prev_ff <= 1'b1;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      refused_ff <= 1'b0;
      cs_ff <= '1;
      rcw_ff <= 3'h7;
      addr_ff <= 14'h0000;
      ba_ff <= 3'h0;
      odt_ff <= 1'b0;
      dqs_ff <= '0;
      dqs_oe_ff <= 1'b0;
      for (int l = 0; l < LANES; l++)
        dly_ff[l] <= 8'h00;
    end
    else
    begin
      st_ff <= nxt_st;
      ret_ff <= nxt_ret;
      cnt_ff <= nxt_cnt;
      lane_ff <= nxt_lane;
      prev_ff <= nxt_prev;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      refused_ff <= nxt_refused;
      cs_ff <= nxt_cs;
      rcw_ff <= nxt_rcw;
      addr_ff <= nxt_addr;
      ba_ff <= nxt_ba;
      odt_ff <= nxt_odt;
      dqs_ff <= nxt_dqs;
      dqs_oe_ff <= nxt_dqs_oe;
      for (int l = 0; l < LANES; l++)
        dly_ff[l] <= nxt_dly[l];
    end
  end

  assign link.ck = ck_ff;
  assign link.cs_n = cs_ff;
  assign link.ras_n = rcw_ff[2];
  assign link.cas_n = rcw_ff[1];
  assign link.we_n = rcw_ff[0];
  assign link.ba = ba_ff;
  assign link.addr = addr_ff;
  assign link.odt = odt_ff;
  assign link.dqs_o = dqs_ff;
  assign link.dqs_n_o = ~dqs_ff;
  assign link.dqs_oe = {LANES{dqs_oe_ff}};
endmodule // wl_ctrl_end

// File: wl_link_sva.sv
/*
  Checker for the write leveling link between the two ends.
  Assumes two lanes, two ranks and the constants of wl_defs.svh.
*/
`timescale 1ns/1ps
`include "wl_defs.svh"
module wl_link_sva #(parameter int DIV = 4) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic odt,
  input wire logic [1:0] dqs_o,
  input wire logic [1:0] dqs_n_o,
  input wire logic [1:0] dqs_oe,
  input wire logic [15:0] dq_w
);
  // ****************************************
  // Run lengths, saturating so reset reads as long ago
  // ****************************************
  localparam int MOD = `WL_MOD_CYC;
  localparam int MRD = `WL_MRD_CYC;
  localparam int DQSEN = `WL_DQSEN_CYC;
  localparam int ODTOFF = `WL_ODT_OFF_CYC;
  logic mrs;
  logic anycs;
  logic [1:0] cs_d_ff;
  logic odt_d_ff;
  logic [7:0] own_ff, any_ff, odt_ff, nxt_own, nxt_any, nxt_odt;

  assign anycs = ~&cs_n;
  assign mrs = anycs & ~ras_n & ~cas_n & ~we_n;

  always_comb
  begin
    nxt_own = own_ff + {7'h00, own_ff != 8'hff};
    nxt_any = any_ff + {7'h00, any_ff != 8'hff};
    nxt_odt = odt_ff + {7'h00, odt_ff != 8'hff};
    if (cs_d_ff[0] & ~cs_n[0])
      nxt_own = 8'h00;
    if (&cs_d_ff & anycs)
      nxt_any = 8'h00;
    if (odt_d_ff != odt)
      nxt_odt = 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_d_ff <= 2'h3;
      odt_d_ff <= 1'b0;
      own_ff <= 8'hff;
      any_ff <= 8'hff;
      odt_ff <= 8'hff;
    end
    else
    begin
      cs_d_ff <= cs_n;
      odt_d_ff <= odt;
      own_ff <= nxt_own;
      any_ff <= nxt_any;
      odt_ff <= nxt_odt;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_mrs_bank_one: assert property (mrs |-> ba == `WL_BA_MR1)
    else $error("mode write not to bank one");
  chk_other_rank_off: assert property (mrs && !cs_n[1] |-> addr[`WL_MR1_QOFF_BIT])
    else $error("other rank mode write leaves outputs on");
  chk_cmd_nop_mrs: assert property (anycs |-> mrs || (ras_n && cas_n && we_n))
    else $error("command other than nop or mode write");
  chk_odt_after_mod: assert property ($rose(odt) |-> own_ff >= MOD + DIV - 1)
    else $error("odt raised too early");
  chk_strobe_after_odt: assert property ($rose(|dqs_oe) |->
    odt && odt_ff >= DQSEN - 1 && dqs_o == 2'h0 && dqs_n_o == 2'h3)
    else $error("strobes driven too early or wrong level");
  // Width 4 matches DIV of the bench
  chk_strobe_one_pulse: assert property ($rose(dqs_o[0]) |-> dqs_o[0] [*4] ##1 !dqs_o[0])
    else $error("strobe pulse width wrong");
  chk_exit_odt_off: assert property ($rose(anycs) |->
    !odt && odt_ff >= ODTOFF - 1 && dqs_oe == 2'h0)
    else $error("mode write while odt or strobes active");
  chk_mrs_spacing: assert property ($rose(anycs) |-> any_ff >= MRD - 1)
    else $error("mode writes too close");
  chk_odt_held_low: assert property ($fell(odt) |=> !odt [*8])
    else $error("odt bounced after release");
  chk_lane_feedback: assert property ((dq_w[7:0] == 8'h00 || dq_w[7:0] == 8'hff) &&
    (dq_w[15:8] == 8'h00 || dq_w[15:8] == 8'hff))
    else $error("feedback bits differ within a lane");
endmodule // wl_link_sva

// File: testbench.sv
/*
  Self-checking bench for the write leveling pair over APB.
  Assumes one device rank on the link and DIV of 4.
*/
`timescale 1ns/1ps
`include "wl_defs.svh"
module testbench;
  // ****************************************
  // Harness
  // ****************************************
  localparam int DIV = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, lvl_on, q_off, dterm, mrs_rdy, cmd_rdy, odt_q, lvl_seen, qoff_seen;
  logic [1:0] sterm;
  logic [2:0] rtt_seen;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int odt_hold = 0;

  wl_link_if #(.LANES(2), .RANKS(2)) link ();
  wl_ctrl_end #(.LANES(2), .RANKS(2), .DIV(DIV)) i_wl_ctrl_end (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
  wl_dram_end i_wl_dram_end (.pclk(pclk), .presetn(presetn),
    .link(link.dram), .leveling_on(lvl_on), .outputs_off(q_off), .strobe_term_on(sterm),
    .data_term_on(dterm), .mrs_ready(mrs_rdy), .cmd_ready(cmd_rdy));
  wl_link_sva #(.DIV(DIV)) i_wl_link_sva (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
    .odt(link.odt), .dqs_o(link.dqs_o), .dqs_n_o(link.dqs_n_o), .dqs_oe(link.dqs_oe),
    .dq_w(link.dq_w));

  always #2 pclk = ~pclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic xchk(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(wr, a, d, r, e);
    if (!wr)
      cmp($sformatf("rdata %h", a), exp, r);
    cmp($sformatf("pslverr %h", a), {31'h0, experr}, {31'h0, e});
  endtask

  // Termination lags odt by a two-flop sync and a register, so judge after three
  always @(negedge pclk)
  begin
    odt_q <= link.odt;
    if (link.odt !== odt_q)
      odt_hold = 0;
    else if (odt_hold < 8)
      odt_hold++;
    if (lvl_on === 1'b1 && odt_hold >= 3)
    begin
      cmp("strobe term", {30'h0, {2{link.odt}}}, {30'h0, sterm});
      cmp("data term", 32'h0, {31'h0, dterm});
    end
    if (link.cs_n[1] === 1'b0)
      qoff_seen = link.addr[12];
    if (link.cs_n[0] === 1'b0 && link.addr[7] === 1'b1)
      rtt_seen = {link.addr[9], link.addr[6], link.addr[2]};
    if (lvl_on === 1'b1)
      lvl_seen = 1'b1;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    xchk(1'b0, `WL_REG_CTRL, 32'h0, 32'h2, 1'b0);
    xchk(1'b0, `WL_REG_STATUS, 32'h0, 32'h0, 1'b0);
    xchk(1'b0, `WL_REG_DELAY, 32'h0, 32'h0, 1'b0);
    xchk(1'b1, 8'h0c, 32'hffffffff, 32'h0, 1'b1);
    xchk(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
  endtask

  task automatic t_refuse();
    for (int c = 4; c < 8; c++)
    begin
      xchk(1'b1, `WL_REG_CTRL, {28'h0, c[2:0], 1'b1}, 32'h0, 1'b0);
      xchk(1'b0, `WL_REG_STATUS, 32'h0, 32'h8, 1'b0);
    end
    xchk(1'b1, `WL_REG_CTRL, 32'h23, 32'h0, 1'b0);
    xchk(1'b0, `WL_REG_STATUS, 32'h0, 32'h8, 1'b0);
    cmp("leveling idle", 32'h0, {31'h0, lvl_on});
  endtask

  task automatic t_level(input logic [2:0] rtt);
    logic [31:0] s;
    logic e;
    int n;
    lvl_seen = 1'b0;
    qoff_seen = 1'b0;
    rtt_seen = 3'h0;
    apb(1'b1, `WL_REG_CTRL, {28'h0, rtt, 1'b1}, s, e);
    n = 0;
    do
    begin
      apb(1'b0, `WL_REG_STATUS, 32'h0, s, e);
      n++;
    end
    while (s[0] !== 1'b0 && n < 3000);
    // Device counters may settle on the very edge that ended the poll
    @(negedge pclk);
    cmp("status", 32'h2, s);
    cmp("entered", 32'h1, {31'h0, lvl_seen});
    cmp("left", 32'h0, {31'h0, lvl_on});
    cmp("rtt sent", {29'h0, rtt}, {29'h0, rtt_seen});
    cmp("other rank off", 32'h1, {31'h0, qoff_seen});
    cmp("own outputs", 32'h0, {31'h0, q_off});
    cmp("cmd ready", 32'h1, {31'h0, cmd_rdy});
    cmp("term off", 32'h0, {30'h0, sterm});
    apb(1'b0, `WL_REG_DELAY, 32'h0, s, e);
    cmp("lane delays", {24'h0, s[7:0]}, {24'h0, s[15:8]});
    cmp("delay in sweep", 32'h1, {31'h0, s[7:0] < 2 * DIV});
  endtask

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_refuse();
    for (int r = 1; r < 4; r++)
      t_level(r[2:0]);
    stop_test();
  end
endmodule // testbench
